// ### emtc_cfg.svh
// Offsets, field positions, reset values and timing tables of the
// external memory timing block. Assumes inclusion by bare name.
`ifndef EMTC_CFG_SVH
`define EMTC_CFG_SVH

`define EMTC_BWC_OFF   8'h00
`define EMTC_MTC_OFF   8'h04
`define EMTC_STS_OFF   8'h08

`define EMTC_BWC_RST   5'h1F
`define EMTC_MTC_RST   16'h0000
`define EMTC_MTC_RMASK 16'hFF7F

`define EMTC_F_A12     4:3
`define EMTC_F_A0      2:0
`define EMTC_F_TPC     15:14
`define EMTC_F_TRWL    11:10
`define EMTC_F_TRAS    9:8
`define EMTC_F_RSV     7
`define EMTC_F_BE      6
`define EMTC_F_SZ      5
`define EMTC_F_AMX     4:3
`define EMTC_F_REFRESH_ON    2
`define EMTC_F_REFRESH_KIND_SELECT   1
`define EMTC_F_EDO     0

`define EMTC_TRWL_RSV  2'h3
`define EMTC_AREA3     2'h3
`define EMTC_AREA0     2'h0
`define EMTC_COL_BASE  4'h8
`define EMTC_BEATS_M1  2'h3
`define EMTC_A3_CYC_M1 5'h03

// Cycles minus one, highest entry first (entry 7, or entry 3 in the four-entry tables)
`define EMTC_A0_FIRST  {5'h0A,5'h08,5'h06,5'h04,5'h03,5'h02,5'h01,5'h00}
`define EMTC_A0_PITCH  {5'h09,5'h07,5'h05,5'h03,5'h03,5'h02,5'h01,5'h01}
`define EMTC_CAS_TBL   {5'h02,5'h01,5'h00,5'h00}
`define EMTC_GAP_SR    {5'h0A,5'h07,5'h04,5'h01}

`define EMTC_RESP_OK   2'h0
`define EMTC_RESP_DEC  2'h3

`endif

// ### emtc_mem_model.sv
// Far-side memory model: drives the external wait line.
// Assumes it shares core_clk with the timing block.
`timescale 1ns/1ns
module emtc_mem_model (
    input  wire logic       core_clk,
    input  wire logic       start,
    input  wire logic [3:0] hold,
    output logic            ext_wait
);
    logic [3:0] cnt_ff = 4'h0;
    // Holds wait for hold cycles after a start
    always_ff @(posedge core_clk) begin
        cnt_ff <= start ? hold : cnt_ff - {3'h0, cnt_ff != 4'h0};
    end
    assign ext_wait = cnt_ff != 4'h0;
endmodule

// ### emtc_pkg.sv
// Types shared by the external memory timing block.
// Assumes emtc_cfg.svh is compiled alongside.
package emtc_pkg;

    typedef enum logic [1:0] {
        MK_NORMAL = 2'h0,
        MK_DRAM   = 2'h1,
        MK_SDRAM  = 2'h2,
        MK_PSRAM  = 2'h3
    } emtc_kind_t;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_ACCESS  = 5'h02,
        ST_GAP     = 5'h04,
        ST_REFRESH = 5'h08,
        ST_SELF    = 5'h10
    } emtc_state_t;

    typedef struct packed {
        logic [1:0] area;
        emtc_kind_t kind;
        logic       write;
        logic       burst;
    } emtc_req_t;

    typedef struct packed {
        logic       applies;
        logic       burst_mode;
        logic       bus_is_32;
        logic [3:0] col_bits;
        logic [1:0] sdram_shift;
        logic       edo_rise_sample;
        logic       ras_half_delay;
    } emtc_tim_t;

endpackage

// ### emtc_top.sv
// External memory timing block: AXI4-Lite registers and access sequencer.
// Assumes one clock, requests synchronous to core_clk, a 10 MHz bus clock.
// Contract
// - Areas 1-2 normal memory: codes 0-3 add 0-3 waits; code 0 masks wait.
// - Areas 1-2 DRAM/SDRAM: codes give CAS period or latency 1,1,2,3.
// - Areas 1-2 honour external wait only for normal memory.
// - Area 0 first cycle waits 0,1,2,3,4,6,8,10; code 0 masks wait.
// - Area 0 later burst beats take 2,2,3,4,4,6,8,10 states, wait honoured.
// - Control register: DRAM in area 3, SDRAM in areas 2-3, pseudo-SRAM.
// - Control register clears on power-on reset only, not manual reset.
// - Precharge gap 1-4 cycles, or 2,5,8,11 after self-refresh.
// - SDRAM write adds write_to_activate_delay 1-3 before activate.
// - Refresh strobe 2-5 cycles; activate_block covers the gap after it, not the strobe.
// - Bit 7 reads zero; software writes zero.
// - Burst enable picks page or continuous mode; SDRAM always bursts.
// - Width bit picks 16 or 32 bits over bus width register.
// - Column select gives 8-11 column bits; SDRAM uses separate shift.
// - Periodic refresh ends a running cycle and starts the refresh.
// - Self-refresh waits for cycle end; refresh requests then ignored.
// - EDO in area 3 DRAM: rising-edge sampling, half-cycle RAS delay.
`timescale 1ns/1ns
`include "emtc_cfg.svh"
module emtc_top (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    input  wire logic                manual_rst_n,
    input  wire logic [31:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [31:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire emtc_pkg::emtc_req_t acc_req,
    input  wire logic                acc_valid,
    output logic                     acc_ready,
    output logic                     acc_done,
    output logic                     acc_abort,
    input  wire logic                ext_wait,
    input  wire logic                refresh_req,
    input  wire logic                bus_width_config_register_wide,
    output emtc_pkg::emtc_tim_t      tim,
    output logic                     refresh_strobe,
    output logic                     self_refresh,
    output logic                     activate_block,
    output logic                     mtc_ready
);
    logic                  rs1_ff;
    logic                  rs2_ff;
    logic                  aw_held_ff;
    logic [7:0]            aw_addr_ff;
    logic                  w_held_ff;
    logic [15:0]           w_data_ff;
    logic [1:0]            w_strb_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  rvalid_ff;
    logic [31:0]           rdata_ff;
    logic [1:0]            rresp_ff;
    logic [4:0]            bwc_ff;
    logic [15:0]           mtc_ff;
    logic                  init_ff;
    emtc_pkg::emtc_state_t state_ff;
    emtc_pkg::emtc_state_t nxt_state;
    logic [4:0]            cnt_ff;
    logic [4:0]            nxt_cnt;
    logic [1:0]            beats_ff;
    logic [1:0]            nxt_beats;
    logic                  first_ff;
    logic                  nxt_first;
    emtc_pkg::emtc_req_t   req_ff;
    logic                  ref_pend_ff;
    logic                  done_ff;
    logic                  abort_ff;
    logic                  nxt_done;
    logic                  nxt_abort;
    emtc_pkg::emtc_tim_t   tim_ff;
    logic [4:0]            first_m1;
    logic [4:0]            pitch_m1;
    logic                  en_first;
    logic                  en_beat;
    logic [4:0]            gap_m1;
    logic [4:0]            gap_wr_m1;
    logic [4:0]            gap_sr_m1;
    logic [4:0]            strobe_m1;

    wire rst_sync_n = rs2_ff;
    wire mrst       = !manual_rst_n;

    // Bus slave: address and data taken in either order, answer follows
    wire aw_hs  = s_axi_awvalid & s_axi_awready;
    wire w_hs   = s_axi_wvalid & s_axi_wready;
    wire ar_hs  = s_axi_arvalid & s_axi_arready;
    wire do_wr  = aw_held_ff & w_held_ff & !bvalid_ff;
    wire wr_bwc = do_wr & (aw_addr_ff == `EMTC_BWC_OFF);
    wire wr_mtc = do_wr & (aw_addr_ff == `EMTC_MTC_OFF);
    wire wr_hit = wr_bwc | wr_mtc | (aw_addr_ff == `EMTC_STS_OFF);
    assign s_axi_awready = !aw_held_ff & !bvalid_ff;
    assign s_axi_wready  = !w_held_ff & !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Byte-lane merge; reserved bit forced low, reserved delay code kept out
    wire [15:0] mtc_lanes = {w_strb_ff[1] ? w_data_ff[15:8] : mtc_ff[15:8],
                             w_strb_ff[0] ? w_data_ff[7:0] : mtc_ff[7:0]};
    wire        trwl_bad  = mtc_lanes[`EMTC_F_TRWL] == `EMTC_TRWL_RSV;
    wire [15:0] mtc_new   = {mtc_lanes[15:12],
                             trwl_bad ? mtc_ff[`EMTC_F_TRWL]
                                      : mtc_lanes[`EMTC_F_TRWL],
                             mtc_lanes[9:0]} & `EMTC_MTC_RMASK;
    wire [4:0]  bwc_new   = w_strb_ff[0] ? w_data_ff[4:0] : bwc_ff;

    wire [7:0]  rd_addr = s_axi_araddr[7:0];
    wire        rd_bwc  = rd_addr == `EMTC_BWC_OFF;
    wire        rd_mtc  = rd_addr == `EMTC_MTC_OFF;
    wire        rd_sts  = rd_addr == `EMTC_STS_OFF;
    wire [31:0] rd_mux  = rd_bwc ? {27'h0, bwc_ff}
                        : rd_mtc ? {16'h0, mtc_ff}
                        : rd_sts ? {25'h0, init_ff, ref_pend_ff, state_ff}
                        : 32'h0;

    wire cbr_mode  = mtc_ff[`EMTC_F_REFRESH_ON] & !mtc_ff[`EMTC_F_REFRESH_KIND_SELECT];
    wire self_mode = mtc_ff[`EMTC_F_REFRESH_ON] & mtc_ff[`EMTC_F_REFRESH_KIND_SELECT];
    wire st_idle   = state_ff == emtc_pkg::ST_IDLE;
    wire st_access = state_ff == emtc_pkg::ST_ACCESS;
    wire st_self   = state_ff == emtc_pkg::ST_SELF;
    wire ref_go    = ref_pend_ff & cbr_mode;
    wire ref_take_hold = state_ff == emtc_pkg::ST_REFRESH;
    wire ref_take  = nxt_state == emtc_pkg::ST_REFRESH && !ref_take_hold;

    // Decode the incoming request at launch, the held one afterwards
    wire emtc_pkg::emtc_req_t dreq = st_idle ? acc_req : req_ff;
    wire is_sd   = dreq.kind == emtc_pkg::MK_SDRAM;
    wire applies = (dreq.kind == emtc_pkg::MK_DRAM
                    && dreq.area == `EMTC_AREA3)
                 | (is_sd && dreq.area[1])
                 | (dreq.kind == emtc_pkg::MK_PSRAM);
    wire bursty  = is_sd | (dreq.burst & (applies ? mtc_ff[`EMTC_F_BE]
                   : dreq.kind == emtc_pkg::MK_NORMAL));
    wire edo     = mtc_ff[`EMTC_F_EDO] & applies & !is_sd
                 & (dreq.kind == emtc_pkg::MK_DRAM);
    wire emtc_pkg::emtc_tim_t tim_new = '{
        applies:         applies,
        burst_mode:      bursty,
        bus_is_32:       applies ? mtc_ff[`EMTC_F_SZ] : bus_width_config_register_wide,
        col_bits:        `EMTC_COL_BASE + {2'h0, mtc_ff[`EMTC_F_AMX]},
        sdram_shift:     is_sd ? mtc_ff[`EMTC_F_AMX] : 2'h0,
        edo_rise_sample: edo,
        ras_half_delay:  edo
    };

    wire wait_en  = first_ff ? en_first : en_beat;
    wire sd_write = req_ff.kind == emtc_pkg::MK_SDRAM && req_ff.write;

    assign acc_ready      = st_idle & !self_mode & !ref_go;
    assign acc_done       = done_ff;
    assign acc_abort      = abort_ff;
    assign tim            = tim_ff;
    assign refresh_strobe = state_ff == emtc_pkg::ST_REFRESH;
    assign self_refresh   = st_self;
    assign activate_block = state_ff == emtc_pkg::ST_GAP;
    assign mtc_ready      = init_ff;

    emtc_wait_decode u_dec (
        .a0_code   (bwc_ff[`EMTC_F_A0]),
        .a12_code  (bwc_ff[`EMTC_F_A12]),
        .tpc       (mtc_ff[`EMTC_F_TPC]),
        .trwl      (mtc_ff[`EMTC_F_TRWL]),
        .tras      (mtc_ff[`EMTC_F_TRAS]),
        .req       (dreq),
        .first_m1  (first_m1),
        .pitch_m1  (pitch_m1),
        .en_first  (en_first),
        .en_beat   (en_beat),
        .gap_m1    (gap_m1),
        .gap_wr_m1 (gap_wr_m1),
        .gap_sr_m1 (gap_sr_m1),
        .strobe_m1 (strobe_m1)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_beats = beats_ff;
        nxt_first = first_ff;
        nxt_done  = 1'b0;
        nxt_abort = 1'b0;
        case (state_ff)
            emtc_pkg::ST_IDLE: begin
                if (self_mode) begin
                    nxt_state = emtc_pkg::ST_SELF;
                end else if (ref_go) begin
                    nxt_state = emtc_pkg::ST_REFRESH;
                    nxt_cnt   = strobe_m1;
                end else if (acc_valid) begin
                    nxt_state = emtc_pkg::ST_ACCESS;
                    nxt_cnt   = first_m1;
                    nxt_first = 1'b1;
                    nxt_beats = bursty ? `EMTC_BEATS_M1 : 2'h0;
                end
            end
            emtc_pkg::ST_ACCESS: begin
                if (ref_go) begin
                    nxt_state = emtc_pkg::ST_REFRESH;
                    nxt_cnt   = strobe_m1;
                    nxt_abort = 1'b1;
                end else if (cnt_ff != 5'h00) begin
                    nxt_cnt = cnt_ff - 5'h01;
                end else if (wait_en & ext_wait) begin
                    nxt_cnt = cnt_ff;
                end else if (beats_ff != 2'h0) begin
                    nxt_beats = beats_ff - 2'h1;
                    nxt_first = 1'b0;
                    nxt_cnt   = pitch_m1;
                end else begin
                    nxt_done  = 1'b1;
                    nxt_state = self_mode ? emtc_pkg::ST_SELF
                                          : emtc_pkg::ST_GAP;
                    nxt_cnt   = sd_write ? gap_wr_m1 : gap_m1;
                end
            end
            emtc_pkg::ST_GAP: begin
                if (cnt_ff != 5'h00) begin
                    nxt_cnt = cnt_ff - 5'h01;
                end else begin
                    nxt_state = emtc_pkg::ST_IDLE;
                end
            end
            emtc_pkg::ST_REFRESH: begin
                if (cnt_ff != 5'h00) begin
                    nxt_cnt = cnt_ff - 5'h01;
                end else begin
                    nxt_state = emtc_pkg::ST_GAP;
                    nxt_cnt   = gap_m1;
                end
            end
            emtc_pkg::ST_SELF: begin
                if (!self_mode) begin
                    nxt_state = emtc_pkg::ST_GAP;
                    nxt_cnt   = gap_sr_m1;
                end
            end
            default: begin
                nxt_state = emtc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_ff <= 1'b0;
            rs2_ff <= 1'b0;
        end else if (clk_en) begin
            rs1_ff <= 1'b1;
            rs2_ff <= rs1_ff;
        end
    end

    // Power-on reset only: manual reset must not disturb these
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mtc_ff  <= `EMTC_MTC_RST;
            bwc_ff  <= `EMTC_BWC_RST;
            init_ff <= 1'b0;
        end else if (clk_en) begin
            if (wr_mtc) mtc_ff <= mtc_new;
            if (wr_bwc) bwc_ff <= bwc_new;
            if (wr_mtc) init_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            rvalid_ff  <= 1'b0;
        end else if (clk_en) begin
            aw_held_ff <= aw_hs | (aw_held_ff & !do_wr);
            w_held_ff  <= w_hs | (w_held_ff & !do_wr);
            bvalid_ff  <= do_wr | (bvalid_ff & !s_axi_bready);
            rvalid_ff  <= ar_hs | (rvalid_ff & !s_axi_rready);
        end
    end

    // Payload registers carry no reset; valid flags guard them
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (aw_hs) aw_addr_ff <= s_axi_awaddr[7:0];
            if (w_hs) w_data_ff <= s_axi_wdata[15:0];
            if (w_hs) w_strb_ff <= s_axi_wstrb[1:0];
            if (do_wr) bresp_ff <= wr_hit ? `EMTC_RESP_OK : `EMTC_RESP_DEC;
            if (ar_hs) rdata_ff <= rd_mux;
            if (ar_hs) rresp_ff <= (rd_bwc | rd_mtc | rd_sts)
                                   ? `EMTC_RESP_OK : `EMTC_RESP_DEC;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff    <= emtc_pkg::ST_IDLE;
            cnt_ff      <= 5'h00;
            beats_ff    <= 2'h0;
            first_ff    <= 1'b0;
            req_ff      <= '0;
            tim_ff      <= '0;
            ref_pend_ff <= 1'b0;
            done_ff     <= 1'b0;
            abort_ff    <= 1'b0;
        end else if (clk_en) begin
            state_ff    <= mrst ? emtc_pkg::ST_IDLE : nxt_state;
            cnt_ff      <= mrst ? 5'h00 : nxt_cnt;
            beats_ff    <= mrst ? 2'h0 : nxt_beats;
            first_ff    <= nxt_first;
            done_ff     <= nxt_done & !mrst;
            abort_ff    <= nxt_abort & !mrst;
            if (st_idle & acc_valid & acc_ready) req_ff <= acc_req;
            if (st_idle & acc_valid & acc_ready) tim_ff <= tim_new;
            // A new request beats the take; self-refresh drops them all
            ref_pend_ff <= !mrst & !st_self
                         & ((refresh_req & mtc_ff[`EMTC_F_REFRESH_ON])
                            | (ref_pend_ff & !ref_take));
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    rsv_bit_zero_a: assert property (mtc_ff[`EMTC_F_RSV] == 1'b0)
        else $error("reserved bit set");
    mtc_hold_a: assert property (mrst && !wr_mtc |=> $stable(mtc_ff))
        else $error("control register lost on manual reset");
    ready_gap_a: assert property (acc_ready |-> !activate_block)
        else $error("ready during precharge gap");
    self_ignore_a: assert property (st_self |-> !ref_pend_ff)
        else $error("refresh pending in self-refresh");
    cbr_abort_a: assert property (clk_en && st_access && ref_go && !mrst
        |=> refresh_strobe && acc_abort)
        else $error("refresh did not end access");
    wait_hold_a: assert property (clk_en && st_access && !ref_go && !mrst
        && cnt_ff == 5'h00 && wait_en && ext_wait |=> st_access)
        else $error("access ended under wait");
    strobe_len_a: assert property ($rose(refresh_strobe)
        |-> refresh_strobe [*2])
        else $error("refresh strobe too short");
    sdram_burst_a: assert property (acc_done && req_ff.kind
        == emtc_pkg::MK_SDRAM |-> tim_ff.burst_mode)
        else $error("sdram access without burst");
    edo_area_a: assert property (tim_ff.edo_rise_sample
        |-> req_ff.area == `EMTC_AREA3)
        else $error("edo sampling outside area 3");
    a12_nowait_a: assert property (st_access && req_ff.area != `EMTC_AREA0
        && req_ff.area != `EMTC_AREA3 && (req_ff.kind != emtc_pkg::MK_NORMAL
        || bwc_ff[`EMTC_F_A12] == 2'h0) |-> !wait_en)
        else $error("wait honoured where masked");

    abort_seen_c: cover property (acc_abort);
    self_entry_c: cover property (st_access ##1 st_self);
    burst_done_c: cover property (acc_done && tim_ff.burst_mode);
    sd_write_gap_c: cover property (acc_done && sd_write);
endmodule

// ### emtc_top_tb_top.sv
// Self-checking bench of the external memory timing block.
// Assumes the design and the memory model are compiled first.
`timescale 1ns/1ns
module emtc_top_tb_top;
    logic clk, rst_n, mrst_n, awv, wv, arv, bry, rry, ar, av, rf;
    logic awr, wr, bv, arr, rv, dn, rs, sr, blk, ew, ok, ab, mr;
    logic [31:0] awa, wd, ara, rd, d;
    logic [1:0] br, rr;
    logic [3:0] hold;
    emtc_pkg::emtc_req_t rq;
    emtc_pkg::emtc_tim_t tm;
    int n_errors, compares, n, s, g;
    emtc_top dut_u (.core_clk(clk), .rst_n(rst_n), .clk_en(1'h1),
        .manual_rst_n(mrst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .acc_req(rq), .acc_valid(av), .acc_ready(ar), .acc_done(dn),
        .acc_abort(ab), .ext_wait(ew), .refresh_req(rf), .bus_width_config_register_wide(1'h0),
        .tim(tm), .refresh_strobe(rs), .self_refresh(sr),
        .activate_block(blk), .mtc_ready(mr));
    emtc_mem_model mem_u (.core_clk(clk), .start(av & ar), .hold(hold),
        .ext_wait(ew));
    task automatic stop_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] v, input logic [31:0] e);
        compares++;
        if (v !== e) begin
            n_errors++;
            $display("ERROR t=%0t seen %h exp %h", $time, v, e);
        end
    endtask
    // A bound that runs out ends the run as a mismatch
    task automatic tmo;
        if (!ok) begin
            n_errors++;
            stop_test;
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [15:0] v);
        logic ta, tw;
        awa <= {24'h0, a};
        wd <= {16'h0, v};
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        repeat (40) begin
            @(negedge clk);
            ta = awr;
            tw = wr;
            ok = bv;
            @(posedge clk);
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
            if (ok) break;
        end
        bry <= 1'h0;
        tmo;
    endtask
    task automatic axr(input logic [7:0] a);
        logic ta;
        ara <= {24'h0, a};
        arv <= 1'h1;
        rry <= 1'h1;
        repeat (40) begin
            @(negedge clk);
            ta = arr;
            ok = rv;
            d = rd;
            @(posedge clk);
            if (ta) arv <= 1'h0;
            if (ok) break;
        end
        rry <= 1'h0;
        tmo;
    endtask
    // Cycles from the take edge until the done or abort pulse land in n
    task automatic acc(input logic [5:0] r, input logic [3:0] h);
        rq <= emtc_pkg::emtc_req_t'(r);
        hold <= h;
        av <= 1'h1;
        repeat (40) begin
            @(negedge clk);
            ok = ar;
            @(posedge clk);
            if (ok) break;
        end
        av <= 1'h0;
        rf <= 1'h0;
        tmo;
        n = 0;
        repeat (60) begin
            @(negedge clk);
            ok = dn | ab;
            if (ok) break;
            n++;
        end
        tmo;
    endtask
    task automatic rfr(input logic p);
        rf <= p;
        s = 0;
        g = 0;
        // First sample falls before the pulse is taken
        repeat (40) begin
            @(negedge clk);
            s += rs;
            g += blk;
            @(posedge clk);
            rf <= 1'h0;
        end
    endtask
    task automatic t_regs;
        axr(8'h04);
        chk(d, 32'h0);
        chk(mr, 32'h0);
        axr(8'h00);
        chk(d, 32'h1F);
        axw(8'h04, 16'hFFF9);
        chk(mr, 32'h1);
        axr(8'h04);
        chk(d, 32'hF379);
        axr(8'h0C);
        chk({30'h0, rr}, 32'h3);
        mrst_n <= 1'h0;
        repeat (2) @(posedge clk);
        mrst_n <= 1'h1;
        axr(8'h04);
        chk(d, 32'hF379);
        $display("test regs done");
    endtask
    task automatic t_wait;
        int w[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
        int c4[4] = '{1, 1, 2, 3};
        for (int c = 0; c < 8; c++) begin
            axw(8'h00, 16'(c));
            acc(6'h00, 4'h0);
            chk(n, w[c] + 1);
        end
        acc(6'h00, 4'hF);
        chk(n, 16);
        axw(8'h00, 16'h2);
        acc(6'h01, 4'h0);
        chk(n, 12);
        for (int c = 0; c < 4; c++) begin
            axw(8'h00, 16'(c * 8));
            acc(6'h10, 4'h0);
            chk(n, c + 1);
            acc(6'h14, 4'h6);
            chk(n, c4[c]);
        end
        $display("test waits done");
    endtask
    task automatic t_mem;
        axw(8'h04, 16'h0030);
        acc(6'h34, 4'h0);
        chk({tm.applies, tm.bus_is_32}, 32'h3);
        chk(tm.col_bits, 32'hA);
        acc(6'h28, 4'h0);
        chk({tm.applies, tm.burst_mode}, 32'h3);
        acc(6'h24, 4'h0);
        chk(tm.applies, 32'h0);
        axw(8'h04, 16'h8204);
        rfr(1'h1);
        chk(s, 4);
        chk(g, 3);
        // Refresh request lands on the take edge and cuts the access
        rf <= 1'h1;
        acc(6'h10, 4'hF);
        chk({ab, rs, dn}, 32'h6);
        chk(n, 1);
        repeat (12) @(posedge clk);
        axw(8'h04, 16'h8206);
        rfr(1'h1);
        chk({sr, ar, s[0]}, 32'h4);
        axw(8'h04, 16'h8200);
        rfr(1'h0);
        chk(g, 8);
        $display("test memory done");
    endtask
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst_n, mrst_n, awv, wv, arv, bry, rry, av, rf} = 9'h080;
        {awa, wd, ara, hold} = '0;
        rq = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        t_regs;
        t_wait;
        t_mem;
        stop_test;
    end
endmodule

// ### emtc_wait_decode.sv
// Wait, pitch, gap and strobe cycle counts (minus one) for one request.
// Assumes the register fields are stable while a request is decoded.
`timescale 1ns/1ns
`include "emtc_cfg.svh"
module emtc_wait_decode (
    input  wire logic [2:0]       a0_code,
    input  wire logic [1:0]       a12_code,
    input  wire logic [1:0]       tpc,
    input  wire logic [1:0]       trwl,
    input  wire logic [1:0]       tras,
    input  wire emtc_pkg::emtc_req_t req,
    output logic      [4:0]       first_m1,
    output logic      [4:0]       pitch_m1,
    output logic                  en_first,
    output logic                  en_beat,
    output logic      [4:0]       gap_m1,
    output logic      [4:0]       gap_wr_m1,
    output logic      [4:0]       gap_sr_m1,
    output logic      [4:0]       strobe_m1
);
    wire [39:0] a0_first = `EMTC_A0_FIRST;
    wire [39:0] a0_pitch = `EMTC_A0_PITCH;
    wire [19:0] cas_tbl  = `EMTC_CAS_TBL;
    wire [19:0] sr_tbl   = `EMTC_GAP_SR;
    wire        is_a0    = req.area == `EMTC_AREA0;
    wire        is_a3    = req.area == `EMTC_AREA3;
    wire        normal   = req.kind == emtc_pkg::MK_NORMAL;
    wire [4:0]  a12_m1   = normal ? {3'h0, a12_code}
                                  : cas_tbl[5*a12_code +: 5];
    wire [4:0]  rest_m1  = is_a3 ? `EMTC_A3_CYC_M1 : a12_m1;

    assign first_m1  = is_a0 ? a0_first[5*a0_code +: 5] : rest_m1;
    assign pitch_m1  = is_a0 ? a0_pitch[5*a0_code +: 5] : rest_m1;
    // Wait pin counts for any memory in area 0, only normal memory elsewhere; code zero masks it in areas 1-2 and for the area 0 first cycle
    assign en_first  = is_a0 ? (a0_code != 3'h0)
                     : normal & (is_a3 | (a12_code != 2'h0));
    assign en_beat   = is_a0 | (normal & (is_a3 | (a12_code != 2'h0)));
    assign gap_m1    = {3'h0, tpc};
    assign gap_wr_m1 = {3'h0, tpc} + {3'h0, trwl} + 5'h01;
    assign gap_sr_m1 = sr_tbl[5*tpc +: 5];
    assign strobe_m1 = {3'h0, tras} + 5'h01;
endmodule
